// ### dv/cfac_top_asserts.sv
// Checker of the condition flag and alignment stage ports.
module cfac_top_asserts (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Issue
  input wire logic issue_valid_in,
  input wire logic [31:0] instr_addr_in,
  input wire logic instr_wide_in,
  input wire logic label_branch_in,
  input wire logic has_cond_in,
  input wire logic [2:0] op_class_in,
  input wire logic set_flags_in,
  input wire logic use_carry_in,
  input wire logic [31:0] operand_a_in,
  input wire logic [31:0] operand_b_in,
  input wire logic mem_valid_in,
  input wire logic [3:0] mem_op_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic misalign_trap_enable_in,
  // Completion
  input wire logic done_valid_out,
  input wire logic executed_out,
  input wire logic squashed_out,
  input wire logic dest_write_out,
  input wire logic [3:0] program_status_word_out,
  input wire logic [31:0] pc_relative_out,
  input wire logic [31:0] next_pc_out,
  input wire logic mem_req_out,
  input wire logic mem_unaligned_out,
  input wire logic misuse_exception_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Port relations
  // ****************************************
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  // Flag and memory causes use only unconditional issues, so the pass decision is known here.
  logic iss;
  logic mem_go;
  assign iss = issue_valid_in && !has_cond_in;
  assign mem_go = iss && mem_valid_in;

  done_split_a: assert property (done_valid_out |-> executed_out ^ squashed_out)
    else $error("completion without exactly one of executed or squashed");
  squash_quiet_a: assert property (squashed_out |-> !dest_write_out && !mem_req_out &&
    !misuse_exception_out && $stable(program_status_word_out))
    else $error("squashed instruction had an effect");
  fault_no_req_a: assert property (misuse_exception_out |-> mem_unaligned_out &&
    !mem_req_out && !dest_write_out)
    else $error("faulting access still performed");
  strict_fault_a: assert property (mem_go && mem_op_in >= 4'h8 && mem_addr_in[1:0] != 2'h0
    |=> misuse_exception_out)
    else $error("unaligned strict access did not fault");
  trap_fault_a: assert property (mem_go && misalign_trap_enable_in && mem_addr_in[0] &&
    mem_op_in == cfac_pkg::MEM_LOAD_WORD |=> misuse_exception_out)
    else $error("trap enable did not fault unaligned word");
  byte_ok_a: assert property (mem_go && mem_op_in inside {4'h5, 4'h6, 4'h7}
    |=> mem_req_out && !mem_unaligned_out)
    else $error("byte access treated as unaligned");
  pc_branch_a: assert property (issue_valid_in && label_branch_in |=>
    pc_relative_out == $past(instr_addr_in) + cfac_pkg::PC_READ_OFFSET)
    else $error("branch pc value wrong");
  pc_label_a: assert property (issue_valid_in && !label_branch_in |=>
    pc_relative_out == (($past(instr_addr_in) + cfac_pkg::PC_READ_OFFSET) & ~32'h0000_0002))
    else $error("label pc value wrong");
  next_pc_a: assert property (issue_valid_in |=> next_pc_out == $past(instr_addr_in) +
    ($past(instr_wide_in) ? cfac_pkg::WIDE_STEP : cfac_pkg::NARROW_STEP))
    else $error("next pc step wrong");
  sub_flags_a: assert property (iss && set_flags_in && !use_carry_in &&
    op_class_in == cfac_pkg::OP_SUB |=> program_status_word_out[2:1] ==
    {$past(operand_a_in) == $past(operand_b_in), $past(operand_a_in) >= $past(operand_b_in)})
    else $error("subtract zero or carry flag wrong");
  idle_hold_a: assert property (!issue_valid_in |=> $stable(program_status_word_out))
    else $error("flags changed with no instruction");
  no_suffix_a: assert property (iss && !set_flags_in && op_class_in inside {3'h1, 3'h2}
    |=> $stable(program_status_word_out))
    else $error("flags changed without update suffix");

  cover property (squashed_out);
  cover property (misuse_exception_out);
  cover property (executed_out && dest_write_out);
endmodule

bind cfac_top cfac_top_asserts u_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .issue_valid_in(issue_valid_in),
  .instr_addr_in(instr_addr_in), .instr_wide_in(instr_wide_in),
  .label_branch_in(label_branch_in), .has_cond_in(has_cond_in), .op_class_in(op_class_in),
  .set_flags_in(set_flags_in), .use_carry_in(use_carry_in), .operand_a_in(operand_a_in),
  .operand_b_in(operand_b_in), .mem_valid_in(mem_valid_in), .mem_op_in(mem_op_in),
  .mem_addr_in(mem_addr_in), .misalign_trap_enable_in(misalign_trap_enable_in),
  .done_valid_out(done_valid_out), .executed_out(executed_out), .squashed_out(squashed_out),
  .dest_write_out(dest_write_out), .program_status_word_out(program_status_word_out),
  .pc_relative_out(pc_relative_out), .next_pc_out(next_pc_out), .mem_req_out(mem_req_out),
  .mem_unaligned_out(mem_unaligned_out), .misuse_exception_out(misuse_exception_out)
);

// ### dv/tb_top.sv
// Testbench for the condition flag and alignment stage.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic issue_valid_in, instr_wide_in, label_branch_in, has_cond_in, if_then_prefix_in;
  logic cond_branch_in, set_flags_in, use_carry_in, shift_carry_valid_in, shift_carry_in;
  logic writes_dest_in, mem_valid_in, misalign_trap_enable_in;
  logic [2:0] op_class_in;
  logic [3:0] cond_in, mem_op_in, program_status_word_out, exp_psw;
  logic [31:0] instr_addr_in, operand_a_in, operand_b_in, logic_result_in, mem_addr_in;
  logic done_valid_out, executed_out, squashed_out, uncovered_cond_out, dest_write_out;
  logic mem_req_out, mem_unaligned_out, misuse_exception_out, ok, flt;
  logic [31:0] result_out, pc_relative_out, next_pc_out, mem_addr_out;
  int err_count = 0;
  int check_count = 0;
  // ****************************************
  // Arithmetic table: op, operands, flags and result expected
  // ****************************************
  logic [2:0] t_op [10] = '{3'h2, 3'h1, 3'h1, 3'h2, 3'h5, 3'h5, 3'h1, 3'h3, 3'h4, 3'h1};
  logic [9:0] t_sf = 10'h23F;
  logic [31:0] t_a [10] = '{32'h1, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h80000000, 32'h0,
    32'h80000000, 32'h1, 32'h5, 32'h80000000, 32'hFFFFFFFF};
  logic [31:0] t_b [10] = '{32'h2, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h1, 32'h5,
    32'h80000000, 32'h0};
  logic [3:0] t_psw [10] = '{4'h8, 4'h9, 4'h6, 4'h3, 4'h5, 4'h9, 4'h9, 4'h6, 4'h7, 4'h6};
  logic [31:0] t_res [10] = '{32'hFFFFFFFF, 32'h80000000, 32'h0, 32'h7FFFFFFF, 32'h0,
    32'h80000000, 32'h2, 32'h0, 32'h0, 32'h0};

  cfac_top uut (
    .clock_in(clock_in), .rstn_in(rstn_in), .issue_valid_in(issue_valid_in),
    .instr_addr_in(instr_addr_in), .instr_wide_in(instr_wide_in),
    .label_branch_in(label_branch_in), .has_cond_in(has_cond_in), .cond_in(cond_in),
    .if_then_prefix_in(if_then_prefix_in), .cond_branch_in(cond_branch_in),
    .op_class_in(op_class_in), .set_flags_in(set_flags_in), .use_carry_in(use_carry_in),
    .operand_a_in(operand_a_in), .operand_b_in(operand_b_in),
    .logic_result_in(logic_result_in), .shift_carry_valid_in(shift_carry_valid_in),
    .shift_carry_in(shift_carry_in), .writes_dest_in(writes_dest_in),
    .mem_valid_in(mem_valid_in), .mem_op_in(mem_op_in), .mem_addr_in(mem_addr_in),
    .misalign_trap_enable_in(misalign_trap_enable_in), .done_valid_out(done_valid_out),
    .executed_out(executed_out), .squashed_out(squashed_out),
    .uncovered_cond_out(uncovered_cond_out), .result_out(result_out),
    .dest_write_out(dest_write_out), .program_status_word_out(program_status_word_out),
    .pc_relative_out(pc_relative_out), .next_pc_out(next_pc_out), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_unaligned_out(mem_unaligned_out),
    .misuse_exception_out(misuse_exception_out)
  );

  always #5 clock_in = ~clock_in;

  function automatic logic pass_of(input logic [3:0] c, input logic [3:0] f);
    case (c)
      4'h0: return f[2];
      4'h1: return !f[2];
      4'h2: return f[1];
      4'h3: return !f[1];
      4'h4: return f[3];
      4'h5: return !f[3];
      4'h6: return f[0];
      4'h7: return !f[0];
      4'h8: return f[1] && !f[2];
      4'h9: return !f[1] || f[2];
      4'hA: return f[3] == f[0];
      4'hB: return f[3] != f[0];
      4'hC: return !f[2] && (f[3] == f[0]);
      4'hD: return f[2] || (f[3] != f[0]);
      default: return 1'b1;
    endcase
  endfunction

  function automatic logic al_of(input logic [3:0] m, input logic [1:0] lo);
    if (m inside {4'h5, 4'h6, 4'h7}) return 1'b1;
    if (m inside {4'h2, 4'h3, 4'h4}) return !lo[0];
    return lo == 2'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // Issue stays high between calls, so back-to-back instructions never glitch it.
  task automatic go();
    issue_valid_in = 1'b1;
    @(negedge clock_in);
    chk("done", 32'h1, {31'h0, done_valid_out});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #20us;
    err_count++;
    summarize();
  end

  initial begin
    {issue_valid_in, instr_wide_in, label_branch_in, has_cond_in, if_then_prefix_in} = '0;
    {cond_branch_in, set_flags_in, use_carry_in, shift_carry_valid_in, shift_carry_in} = '0;
    {writes_dest_in, mem_valid_in, misalign_trap_enable_in, op_class_in} = '0;
    {cond_in, mem_op_in, instr_addr_in, operand_a_in, operand_b_in} = '0;
    {logic_result_in, mem_addr_in} = '0;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    rstn_in = 1'b1;
    writes_dest_in = 1'b1;
    for (int i = 0; i < 10; i++) begin
      has_cond_in = 1'b0;
      op_class_in = t_op[i];
      set_flags_in = t_sf[i];
      operand_a_in = t_a[i];
      operand_b_in = t_b[i];
      logic_result_in = t_a[i];
      shift_carry_valid_in = (i == 4);
      use_carry_in = (i == 9);
      go();
      exp_psw = t_psw[i];
      chk("flags", exp_psw, program_status_word_out);
      chk("result", t_res[i], result_out);
      for (int c = 0; c < 16; c++) begin
        op_class_in = 3'h0;
        has_cond_in = 1'b1;
        if_then_prefix_in = 1'b1;
        cond_in = c[3:0];
        go();
        ok = pass_of(c[3:0], exp_psw);
        chk("executed", ok, executed_out);
        chk("dest_write", ok, dest_write_out);
      end
    end
    op_class_in = 3'h2;
    cond_in = 4'h1;
    mem_valid_in = 1'b1;
    mem_op_in = 4'h8;
    mem_addr_in = 32'h2;
    go();
    chk("squashed", 32'h1, squashed_out);
    chk("flags", exp_psw, program_status_word_out);
    chk("misuse", 32'h0, misuse_exception_out);
    if_then_prefix_in = 1'b0;
    op_class_in = 3'h0;
    mem_valid_in = 1'b0;
    go();
    chk("executed", 32'h1, executed_out);
    chk("uncovered", 32'h1, uncovered_cond_out);
    cond_branch_in = 1'b1;
    go();
    chk("squashed", 32'h1, squashed_out);
    has_cond_in = 1'b0;
    instr_addr_in = 32'h1002;
    for (int k = 0; k < 4; k++) begin
      instr_wide_in = k[0];
      label_branch_in = k[1];
      go();
      chk("pc_rel", k[1] ? 32'h1006 : 32'h1004, pc_relative_out);
      chk("next_pc", k[0] ? 32'h1006 : 32'h1004, next_pc_out);
    end
    mem_valid_in = 1'b1;
    for (int m = 0; m < 14; m++) begin
      for (int n = 0; n < 8; n++) begin
        mem_op_in = m[3:0];
        mem_addr_in = 32'h100 + n[1:0];
        misalign_trap_enable_in = n[2];
        go();
        ok = al_of(m[3:0], n[1:0]);
        flt = !ok && (m > 4 || n[2]);
        chk("unaligned", !ok, mem_unaligned_out);
        chk("misuse", flt, misuse_exception_out);
        chk("mem_req", !flt, mem_req_out);
        chk("mem_addr", 32'h100 + n[1:0], mem_addr_out);
      end
    end
    issue_valid_in = 1'b0;
    mem_valid_in = 1'b0;
    @(negedge clock_in);
    chk("idle done", 32'h0, done_valid_out);
    chk("idle flags", exp_psw, program_status_word_out);
    summarize();
  end
endmodule

// ### src/cfac_align_check.sv
// Address alignment checker for loads and stores.
module cfac_align_check (
  cfac_chk_if.align_side chk
);
  logic permitted;

  // ****************************************
  // Alignment and fault decision
  // ****************************************
  always_comb begin
    permitted = 1'b0;
    unique case (chk.mem_op)
      cfac_pkg::MEM_LOAD_BYTE,
      cfac_pkg::MEM_STORE_BYTE,
      cfac_pkg::MEM_LOAD_SBYTE: chk.aligned = 1'b1;
      cfac_pkg::MEM_LOAD_HALF,
      cfac_pkg::MEM_STORE_HALF,
      cfac_pkg::MEM_LOAD_SHALF: begin
        chk.aligned = !chk.addr[0];
        permitted = 1'b1;
      end
      cfac_pkg::MEM_LOAD_WORD,
      cfac_pkg::MEM_STORE_WORD: begin
        chk.aligned = (chk.addr[1:0] == 2'h0);
        permitted = 1'b1;
      end
      default: chk.aligned = (chk.addr[1:0] == 2'h0);
    endcase
    // Permitted unaligned forms still trap when software asks for it.
    chk.fault = !chk.aligned && (!permitted || chk.trap_en);
  end
endmodule

// ### src/cfac_chk_if.sv
// Interface joining the core stage to the condition and alignment checkers.
interface cfac_chk_if;
  logic [3:0] flags;
  cfac_pkg::cfac_cond_type cond;
  logic pass;
  cfac_pkg::cfac_mem_op_type mem_op;
  logic [31:0] addr;
  logic trap_en;
  logic aligned;
  logic fault;

  modport core (
    output flags, cond, mem_op, addr, trap_en,
    input pass, aligned, fault
  );
  modport cond_side (
    input flags, cond,
    output pass
  );
  modport align_side (
    input mem_op, addr, trap_en,
    output aligned, fault
  );
endinterface

// ### src/cfac_cond_eval.sv
// Condition code evaluator against the committed flags.
module cfac_cond_eval (
  cfac_chk_if.cond_side chk
);
  logic n;
  logic z;
  logic c;
  logic v;

  // ****************************************
  // Decision
  // ****************************************
  always_comb begin
    n = chk.flags[cfac_pkg::FLAG_NEG];
    z = chk.flags[cfac_pkg::FLAG_ZERO];
    c = chk.flags[cfac_pkg::FLAG_CARRY];
    v = chk.flags[cfac_pkg::FLAG_OVF];
    unique case (chk.cond)
      cfac_pkg::COND_EQUAL: chk.pass = z;
      cfac_pkg::COND_NOT_EQUAL: chk.pass = !z;
      cfac_pkg::COND_CARRY_SET: chk.pass = c;
      cfac_pkg::COND_CARRY_CLEAR: chk.pass = !c;
      cfac_pkg::COND_NEGATIVE: chk.pass = n;
      cfac_pkg::COND_POSITIVE: chk.pass = !n;
      cfac_pkg::COND_OVF_SET: chk.pass = v;
      cfac_pkg::COND_OVF_CLEAR: chk.pass = !v;
      cfac_pkg::COND_HIGHER: chk.pass = c && !z;
      cfac_pkg::COND_LOWER_SAME: chk.pass = !c || z;
      cfac_pkg::COND_GREATER_EQUAL: chk.pass = (n == v);
      cfac_pkg::COND_LESS: chk.pass = (n != v);
      cfac_pkg::COND_GREATER: chk.pass = !z && (n == v);
      cfac_pkg::COND_LESS_EQUAL: chk.pass = z || (n != v);
      cfac_pkg::COND_ALWAYS: chk.pass = 1'b1;
      // The spare code is treated as always so a stray value never hangs the core.
      default: chk.pass = 1'b1;
    endcase
  end
endmodule

// ### src/cfac_pkg.sv
// Package of constants and types for the condition flag and alignment block.
package cfac_pkg;

  // ****************************************
  // Flag positions in the status word
  // ****************************************
  localparam int FLAG_NEG = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_CARRY = 1;
  localparam int FLAG_OVF = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // ****************************************
  // Program counter offsets
  // ****************************************
  localparam logic [31:0] PC_READ_OFFSET = 32'h0000_0004;
  localparam int PC_ALIGN_BIT = 1;
  localparam logic [31:0] NARROW_STEP = 32'h0000_0002;
  localparam logic [31:0] WIDE_STEP = 32'h0000_0004;

  // ****************************************
  // Condition codes
  // ****************************************
  typedef enum logic [3:0] {
    COND_EQUAL = 4'h0,
    COND_NOT_EQUAL = 4'h1,
    COND_CARRY_SET = 4'h2,
    COND_CARRY_CLEAR = 4'h3,
    COND_NEGATIVE = 4'h4,
    COND_POSITIVE = 4'h5,
    COND_OVF_SET = 4'h6,
    COND_OVF_CLEAR = 4'h7,
    COND_HIGHER = 4'h8,
    COND_LOWER_SAME = 4'h9,
    COND_GREATER_EQUAL = 4'hA,
    COND_LESS = 4'hB,
    COND_GREATER = 4'hC,
    COND_LESS_EQUAL = 4'hD,
    COND_ALWAYS = 4'hE
  } cfac_cond_type;

  // ****************************************
  // Flag-setting operation classes
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD = 3'h1,
    OP_SUB = 3'h2,
    OP_COMPARE = 3'h3,
    OP_COMPARE_NEGATIVE = 3'h4,
    OP_LOGIC = 3'h5
  } cfac_op_type;

  // ****************************************
  // Load and store kinds
  // ****************************************
  typedef enum logic [3:0] {
    MEM_LOAD_WORD = 4'h0,
    MEM_STORE_WORD = 4'h1,
    MEM_LOAD_HALF = 4'h2,
    MEM_STORE_HALF = 4'h3,
    MEM_LOAD_SHALF = 4'h4,
    MEM_LOAD_BYTE = 4'h5,
    MEM_STORE_BYTE = 4'h6,
    MEM_LOAD_SBYTE = 4'h7,
    MEM_LOAD_DUAL = 4'h8,
    MEM_STORE_DUAL = 4'h9,
    MEM_LOAD_MULTI = 4'hA,
    MEM_STORE_MULTI = 4'hB,
    MEM_LOAD_EXCL = 4'hC,
    MEM_STORE_EXCL = 4'hD
  } cfac_mem_op_type;

endpackage

// ### src/cfac_top.sv
// Condition flags, conditional execution and alignment check stage.
//
// Operation
// - Byte always aligned; half and word need alignment.
// - Unaligned allowed only word, halfword, signed-halfword.
// - Other unaligned load or store raises misuse exception.
// - Trap enable makes every unaligned access fault.
// - Branches see current address plus four.
// - Other label users see plus four, bit one cleared.
// - Flags not updated keep their previous value.
// - Failed condition: no execute, write, flags, exception.
// - Condition applies only under if-then or branch.
// - Negative and zero flags follow the result.
// - Addition carry is unsigned carry out.
// - Subtraction carry is inverted borrow.
// - Shifting logic ops take last shifted-out bit.
// - Other logic ops leave carry unchanged.
// - Overflow when sign differs from infinite precision.
// - Compares set flags like subtract or add.
// - Flags update only when the set suffix given, or on compares.
// - Simple conditions test one flag each.
// - Higher is carry and not zero; complement.
// - Signed conditions compare negative with overflow.
// - Always passes and is the default.
// - Both narrow and wide encodings accepted.
module cfac_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Instruction issue
  input wire logic issue_valid_in,
  input wire logic [31:0] instr_addr_in,
  input wire logic instr_wide_in,
  input wire logic label_branch_in,
  // Condition
  input wire logic has_cond_in,
  input wire logic [3:0] cond_in,
  input wire logic if_then_prefix_in,
  input wire logic cond_branch_in,
  // Data processing
  input wire logic [2:0] op_class_in,
  input wire logic set_flags_in,
  input wire logic use_carry_in,
  input wire logic [31:0] operand_a_in,
  input wire logic [31:0] operand_b_in,
  input wire logic [31:0] logic_result_in,
  input wire logic shift_carry_valid_in,
  input wire logic shift_carry_in,
  input wire logic writes_dest_in,
  // Load and store
  input wire logic mem_valid_in,
  input wire logic [3:0] mem_op_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic misalign_trap_enable_in,
  // Completion
  output logic done_valid_out,
  output logic executed_out,
  output logic squashed_out,
  output logic uncovered_cond_out,
  output logic [31:0] result_out,
  output logic dest_write_out,
  output logic [3:0] program_status_word_out,
  // Program counter
  output logic [31:0] pc_relative_out,
  output logic [31:0] next_pc_out,
  // Memory request
  output logic mem_req_out,
  output logic [31:0] mem_addr_out,
  output logic mem_unaligned_out,
  output logic misuse_exception_out
);

  // ****************************************
  // Checker connections
  // ****************************************
  cfac_chk_if chk ();

  cfac_cond_eval u_cond (
    .chk(chk)
  );

  cfac_align_check u_align (
    .chk(chk)
  );

  // ****************************************
  // Registered state
  // ****************************************
  logic [3:0] flags;
  logic done_valid;
  logic executed;
  logic squashed;
  logic uncovered_cond;
  logic [31:0] result;
  logic dest_write;
  logic [31:0] pc_relative;
  logic [31:0] next_pc;
  logic mem_req;
  logic [31:0] mem_addr;
  logic mem_unaligned;
  logic misuse_exception;

  logic [3:0] next_flags;
  logic next_done_valid;
  logic next_executed;
  logic next_squashed;
  logic next_uncovered_cond;
  logic [31:0] next_result;
  logic next_dest_write;
  logic [31:0] next_pc_relative;
  logic [31:0] next_next_pc;
  logic next_mem_req;
  logic [31:0] next_mem_addr;
  logic next_mem_unaligned;
  logic next_misuse_exception;

  // ****************************************
  // Working signals
  // ****************************************
  cfac_pkg::cfac_op_type op;
  logic cond_applies;
  logic run;
  logic fault;
  logic is_add;
  logic is_sub;
  logic discard;
  logic carry_in;
  logic [31:0] b_eff;
  logic [32:0] sum;
  logic [31:0] alu_result;
  logic [31:0] pc_plus;
  logic update_flags;
  logic [3:0] calc_flags;

  // ****************************************
  // Condition selection
  // ****************************************
  always_comb begin
    // A suffix outside an if-then block is not honoured, except on branches.
    cond_applies = has_cond_in && (if_then_prefix_in || cond_branch_in);
    chk.cond = cond_applies ? cfac_pkg::cfac_cond_type'(cond_in)
                            : cfac_pkg::COND_ALWAYS;
    // Flags register already holds the last committed update.
    chk.flags = flags;
    chk.mem_op = cfac_pkg::cfac_mem_op_type'(mem_op_in);
    chk.addr = mem_addr_in;
    chk.trap_en = misalign_trap_enable_in;
  end

  // ****************************************
  // Adder and flag computation
  // ****************************************
  always_comb begin
    op = cfac_pkg::cfac_op_type'(op_class_in);
    is_add = (op == cfac_pkg::OP_ADD) || (op == cfac_pkg::OP_COMPARE_NEGATIVE);
    is_sub = (op == cfac_pkg::OP_SUB) || (op == cfac_pkg::OP_COMPARE);
    discard = (op == cfac_pkg::OP_COMPARE) || (op == cfac_pkg::OP_COMPARE_NEGATIVE);
    // Subtraction adds the inverse; carry in is one, or the flag with carry.
    b_eff = is_sub ? ~operand_b_in : operand_b_in;
    if (use_carry_in) begin
      carry_in = flags[cfac_pkg::FLAG_CARRY];
    end else begin
      carry_in = is_sub;
    end
    sum = {1'b0, operand_a_in} + {1'b0, b_eff} + {32'h0000_0000, carry_in};
    alu_result = (is_add || is_sub) ? sum[31:0] : logic_result_in;
    calc_flags = flags;
    if (is_add || is_sub) begin
      // Carry out equals no-borrow when the subtrahend was inverted.
      calc_flags[cfac_pkg::FLAG_CARRY] = sum[32];
      calc_flags[cfac_pkg::FLAG_OVF] = (operand_a_in[31] == b_eff[31]) &&
                                       (sum[31] != operand_a_in[31]);
    end else if (shift_carry_valid_in) begin
      calc_flags[cfac_pkg::FLAG_CARRY] = shift_carry_in;
    end
    // Without a shift the carry stays as it was.
    calc_flags[cfac_pkg::FLAG_NEG] = alu_result[31];
    calc_flags[cfac_pkg::FLAG_ZERO] = (alu_result == 32'h0000_0000);
  end

  // ****************************************
  // Execute decision and outputs
  // ****************************************
  always_comb begin
    run = issue_valid_in && chk.pass;
    fault = run && mem_valid_in && chk.fault;
    // Compares always set flags; others only with the suffix.
    update_flags = run && !fault && (op != cfac_pkg::OP_NONE) &&
                   (set_flags_in || discard);
    next_done_valid = issue_valid_in;
    next_executed = run;
    next_squashed = issue_valid_in && !chk.pass;
    next_uncovered_cond = issue_valid_in && has_cond_in && !cond_applies;
    next_result = run ? alu_result : result;
    next_dest_write = run && writes_dest_in && !discard && !fault;
    next_mem_req = run && mem_valid_in && !fault;
    next_mem_addr = mem_valid_in ? mem_addr_in : mem_addr;
    next_mem_unaligned = run && mem_valid_in && !chk.aligned;
    next_misuse_exception = fault;
    pc_plus = instr_addr_in + cfac_pkg::PC_READ_OFFSET;
    if (label_branch_in) begin
      next_pc_relative = pc_plus;
    end else begin
      next_pc_relative = pc_plus;
      next_pc_relative[cfac_pkg::PC_ALIGN_BIT] = 1'b0;
    end
    // Both encoding widths step the sequential address.
    next_next_pc = instr_addr_in + (instr_wide_in ? cfac_pkg::WIDE_STEP
                                                  : cfac_pkg::NARROW_STEP);
    if (!issue_valid_in) begin
      next_pc_relative = pc_relative;
      next_next_pc = next_pc;
    end
  end

  // ****************************************
  // Flag state
  // ****************************************
  always_comb begin
    // A squashed or faulting instruction leaves every flag as it was.
    next_flags = update_flags ? calc_flags : flags;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags <= cfac_pkg::FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************
  // Completion registers
  // ****************************************
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_valid <= 1'b0;
      executed <= 1'b0;
      squashed <= 1'b0;
      uncovered_cond <= 1'b0;
      result <= 32'h0000_0000;
      dest_write <= 1'b0;
    end else begin
      done_valid <= next_done_valid;
      executed <= next_executed;
      squashed <= next_squashed;
      uncovered_cond <= next_uncovered_cond;
      result <= next_result;
      dest_write <= next_dest_write;
    end
  end

  // ****************************************
  // Program counter registers
  // ****************************************
  // Both values hold while nothing issues, so a stalled stage still shows them.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_relative <= 32'h0000_0000;
      next_pc <= 32'h0000_0000;
    end else begin
      pc_relative <= next_pc_relative;
      next_pc <= next_next_pc;
    end
  end

  // ****************************************
  // Memory request registers
  // ****************************************
  // The request pulses once; the address stays for the load and store unit.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_unaligned <= 1'b0;
      misuse_exception <= 1'b0;
    end else begin
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      mem_unaligned <= next_mem_unaligned;
      misuse_exception <= next_misuse_exception;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  assign done_valid_out = done_valid;
  assign executed_out = executed;
  assign squashed_out = squashed;
  assign uncovered_cond_out = uncovered_cond;
  assign result_out = result;
  assign dest_write_out = dest_write;
  assign program_status_word_out = flags;
  assign pc_relative_out = pc_relative;
  assign next_pc_out = next_pc;
  assign mem_req_out = mem_req;
  assign mem_addr_out = mem_addr;
  assign mem_unaligned_out = mem_unaligned;
  assign misuse_exception_out = misuse_exception;

endmodule
